// ### verilog/alc_pkg.sv
// Overview of operation
// - each channel low-limit nibble sits in bits 7-4, read/write, resets to zero
// - bits 3-0 of each low-limit nibble register always read zero, writes ignored
// - channel threshold is high byte above nibble, lowest four bits zero
// - read-back of register 3Fh returns the command of the last frame of 16 or more clocks that was not a write to 3Fh
// - echoed byte leaves on data out from 16th falling edge, MSB first
// - eight echoed bits then eight zeros; host may stop after 24th cycle
// - read-back register holds upper byte of previous command, read-only, resets zero
package alc_pkg;

	// channel count and register map
	localparam int         NUM_CH          = 8;
	localparam logic [6:0] ADDR_LT_LSB_CH0 = 7'h19;
	localparam logic [6:0] ADDR_CH_STRIDE  = 7'h05;
	localparam logic [6:0] ADDR_CMD_ECHO   = 7'h3f;

	// frame bit counts
	localparam logic [5:0] BITS_CMD       = 6'h10;
	localparam logic [5:0] CMD_LAST_BIT   = BITS_CMD - 6'h01;
	localparam logic [5:0] BITS_FRAME_MAX = 6'h20;

	// field positions in the register byte
	localparam int NIB_MSB = 7;
	localparam int NIB_LSB = 4;

	// reset and fixed values
	localparam logic [3:0] LT_NIB_RESET = 4'h0;
	localparam logic [3:0] LT_RO_BITS   = 4'h0;
	localparam logic [7:0] ECHO_RESET   = 8'h00;
	localparam logic [7:0] ECHO_PAD     = 8'h00;
	localparam logic [15:0] THR_RESET   = 16'h0000;

	typedef logic [3:0]  alc_nib_t;
	typedef logic [2:0]  alc_ch_t;
	typedef logic [15:0] alc_thr_t;

	// 16-bit command word as it arrives on the serial input
	typedef struct packed {
		logic [6:0] addr;
		logic       wr;
		logic [7:0] data;
	} alc_cmd_s;

	// one executed frame, handed from the link domain to the system domain
	typedef struct packed {
		logic [7:0] echo;
		logic       nibWr;
		alc_ch_t    ch;
		alc_nib_t   nib;
	} alc_evt_s;

endpackage

// ### verilog/alc_sync2.sv
`timescale 1ns/1ps
// two-stage level synchroniser; first stage feeds only the second
module alc_sync2
	import alc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// destination clock
	input  wire logic             clk,
	// asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	// no reset: a synchroniser only has to settle, not start known
	always_ff @(posedge clk)
	begin
		stage1_q <= d;
		stage2_q <= stage1_q;
	end

	assign q = stage2_q;

endmodule

// ### verilog/alc_regs.sv
`timescale 1ns/1ps
// low-alarm nibble registers and command echo behind the serial port
module alc_regs
	import alc_pkg::*;
(
	// system clock and reset
	input  wire logic                    clk,
	input  wire logic                    rstn,

	// threshold high bytes from the neighbouring register block
	input  wire logic [NUM_CH-1:0][7:0]  lowAlarmMsb,

	// thresholds and echo towards the alarm logic
	output alc_thr_t  [NUM_CH-1:0]       lowAlarmThreshold,
	output logic      [7:0]              prevCommand,

	// serial port
	input  wire logic                    sclk,
	input  wire logic                    csN,
	input  wire logic                    sdi,
	output logic                         sdo
);

	// ---------------- link domain ----------------

	logic                     linkRstn;
	logic [5:0]               bitCnt_q;
	logic [5:0]               bitCnt_d;
	logic [14:0]              shIn_q;
	logic [14:0]              shIn_d;
	alc_cmd_s                 cmdWord;
	logic                     cmdDone;
	logic [NUM_CH-1:0]        chHit;
	logic [NUM_CH-1:0][7:0]   rdTerm;
	logic [NUM_CH-1:0][3:0]   nib_q;
	logic [NUM_CH-1:0][3:0]   nib_d;
	logic [7:0]               echo_q;
	logic [7:0]               echo_d;
	logic [7:0]               rdByte_q;
	logic [7:0]               rdByte_d;
	alc_evt_s                 evt_q;
	alc_evt_s                 evt_d;
	logic                     evtTog_q;
	logic                     evtTog_d;
	logic [15:0]              outSh_q;
	logic [15:0]              outSh_d;

	// reset reaches the link side through two flops on the serial clock
	alc_sync2 #(.WIDTH(1)) uRstSync
	(
		.clk (sclk),
		.d   (rstn),
		.q   (linkRstn)
	);

	// frame counter and input shifter; the counter saturates so long frames stay harmless
	always_comb
	begin
		bitCnt_d = bitCnt_q;
		if (bitCnt_q != BITS_FRAME_MAX)
			bitCnt_d = bitCnt_q + 6'h01;
		shIn_d = {shIn_q[13:0], sdi};
	end

	// chip select high ends the frame at once, even with the clock stopped
	always_ff @(posedge sclk or posedge csN)
	begin
		if (csN)
		begin
			bitCnt_q <= 6'h00;
			shIn_q   <= 15'h0000;
		end
		else
		begin
			bitCnt_q <= bitCnt_d;
			shIn_q   <= shIn_d;
		end
	end

	// the 16th rising edge completes the command word
	assign cmdWord = alc_cmd_s'({shIn_q, sdi});
	assign cmdDone = (bitCnt_q == CMD_LAST_BIT);

	// per-channel address decode and read-back term
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : genCh
			assign chHit[g]  = (cmdWord.addr == 7'(ADDR_LT_LSB_CH0 + ADDR_CH_STRIDE * g));
			assign rdTerm[g] = chHit[g] ? {nib_q[g], LT_RO_BITS} : 8'h00;
		end
	endgenerate

	// command execution: nibble writes, read-back byte, echo capture, hand-over event
	always_comb
	begin
		nib_d    = nib_q;
		echo_d   = echo_q;
		rdByte_d = rdByte_q;
		evt_d    = evt_q;
		evtTog_d = evtTog_q;
		if (cmdDone)
		begin
			rdByte_d = 8'h00;
			for (int k = 0; k < NUM_CH; k++)
				rdByte_d = rdByte_d | rdTerm[k];
			if (cmdWord.addr == ADDR_CMD_ECHO)
				rdByte_d = echo_q;
			// a write aimed at the echo register leaves echo, nibbles and event untouched; only the read-back byte loads
			if (!(cmdWord.wr && (cmdWord.addr == ADDR_CMD_ECHO)))
			begin
				echo_d      = {cmdWord.addr, cmdWord.wr};
				evt_d.echo  = {cmdWord.addr, cmdWord.wr};
				evt_d.nibWr = 1'b0;
				for (int k = 0; k < NUM_CH; k++)
				begin
					if (cmdWord.wr && chHit[k])
					begin
						nib_d[k]    = cmdWord.data[NIB_MSB:NIB_LSB];
						evt_d.nibWr = 1'b1;
						evt_d.ch    = alc_ch_t'(k);
						evt_d.nib   = cmdWord.data[NIB_MSB:NIB_LSB];
					end
				end
				evtTog_d = ~evtTog_q;
			end
		end
	end

	// persistent link-side state; reset needs a few serial clock edges to land
	always_ff @(posedge sclk)
	begin
		if (!linkRstn)
		begin
			for (int k = 0; k < NUM_CH; k++)
				nib_q[k] <= LT_NIB_RESET;
			echo_q   <= ECHO_RESET;
			rdByte_q <= 8'h00;
			evt_q    <= '0;
			evtTog_q <= 1'b0;
		end
		else
		begin
			nib_q    <= nib_d;
			echo_q   <= echo_d;
			rdByte_q <= rdByte_d;
			evt_q    <= evt_d;
			evtTog_q <= evtTog_d;
		end
	end

	// output shifter: loads at the 16th falling edge, then byte then zero pad
	always_comb
	begin
		outSh_d = {outSh_q[14:0], 1'b0};
		if (bitCnt_q == BITS_CMD)
			outSh_d = {rdByte_q, ECHO_PAD};
	end

	// falling-edge launch gives the host a half cycle of setup before its rising-edge sample
	always_ff @(negedge sclk or posedge csN)
	begin
		if (csN)
			outSh_q <= 16'h0000;
		else
			outSh_q <= outSh_d;
	end

	assign sdo = outSh_q[15];

	// ---------------- system domain ----------------

	logic                     togSync;
	logic                     togSeen_q;
	logic                     togSeen_d;
	logic                     evtNew;
	logic [NUM_CH-1:0][3:0]   lowNib_q;
	logic [NUM_CH-1:0][3:0]   lowNib_d;
	logic [7:0]               prevCommand_d;
	alc_thr_t [NUM_CH-1:0]    thr_d;

	// event toggle crosses on two flops; the event word is held still until the next frame
	alc_sync2 #(.WIDTH(1)) uTogSync
	(
		.clk (clk),
		.d   (evtTog_q),
		.q   (togSync)
	);

	assign evtNew = togSync ^ togSeen_q;

	// take the held event once per toggle; frames are far slower than the sync delay
	always_comb
	begin
		togSeen_d     = togSync;
		lowNib_d      = lowNib_q;
		prevCommand_d = prevCommand;
		if (evtNew)
		begin
			prevCommand_d = evt_q.echo;
			if (evt_q.nibWr)
				lowNib_d[evt_q.ch] = evt_q.nib;
		end
	end

	// threshold assembly per channel
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : genThr
			assign thr_d[g] = {lowAlarmMsb[g], lowNib_q[g], LT_RO_BITS};
		end
	endgenerate

	// system-side registers; outputs come straight from here
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			togSeen_q   <= 1'b0;
			prevCommand <= ECHO_RESET;
			for (int k = 0; k < NUM_CH; k++)
			begin
				lowNib_q[k]          <= LT_NIB_RESET;
				lowAlarmThreshold[k] <= THR_RESET;
			end
		end
		else
		begin
			togSeen_q         <= togSeen_d;
			prevCommand       <= prevCommand_d;
			lowNib_q          <= lowNib_d;
			lowAlarmThreshold <= thr_d;
		end
	end

endmodule

// ### testbench/alc_regs_assertions.sv
`timescale 1ns/1ps
// port checks beside the register block
module alc_regs_assertions
	import alc_pkg::*;
(
	// block ports
	input wire logic			clk,
	input wire logic			rstn,
	input wire logic [NUM_CH-1:0][7:0]	lowAlarmMsb,
	input wire alc_thr_t [NUM_CH-1:0]	lowAlarmThreshold,
	input wire logic [7:0]			prevCommand,
	input wire logic			sclk,
	input wire logic			csN,
	input wire logic			sdi,
	input wire logic			sdo
);
	logic [5:0]	cnt_d;
	logic [5:0]	cnt_q;
	logic [15:0]	cmd_d;
	logic [15:0]	cmd_q;

	// frame position and received word; a raised select restarts the count
	assign cnt_d = csN ? 6'h00 : cnt_q + 6'h01;
	assign cmd_d = cnt_q < 6'h10 ? {cmd_q[14:0], sdi} : cmd_q;
	always_ff @(posedge sclk or posedge csN)
	begin
		if (csN)
		begin
			cnt_q <= 6'h00;
			cmd_q <= 16'h0000;
		end
		else
		begin
			cnt_q <= cnt_d;
			cmd_q <= cmd_d;
		end
	end

	// system side
	chk_thr_low: assert property (@(posedge clk) disable iff (!rstn)
		lowAlarmThreshold[0][3:0] == 4'h0) else $error("low bits set");
	chk_thr_msb: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |-> lowAlarmThreshold[0][15:8] == $past(lowAlarmMsb[0])) else $error("msb stale");
	chk_rst_zero: assert property (@(posedge clk) disable iff (!rstn)
		!$past(rstn) |-> lowAlarmThreshold[3] == 16'h0000 && prevCommand == 8'h00)
		else $error("not cleared");
	chk_echo_hold: assert property (@(posedge clk) disable iff (!rstn)
		csN [*6] |=> $stable(prevCommand)) else $error("echo moved");
	chk_sdo_idle: assert property (@(posedge clk) disable iff (!rstn)
		csN && $past(csN) |-> !sdo) else $error("sdo high idle");
	// serial side, sampled where the host takes the bits
	chk_nib_read: assert property (@(posedge sclk) disable iff (!rstn)
		cnt_q[5:2] == 4'h4 && cmd_q[15:8] == {ADDR_LT_LSB_CH0, 1'b0}
		|-> sdo == lowAlarmThreshold[0][6'h17 - cnt_q]) else $error("nibble bit");
	chk_nib_ro: assert property (@(posedge sclk) disable iff (!rstn)
		cnt_q[5:2] == 4'h5 && cmd_q[15:9] == ADDR_LT_LSB_CH0 |-> !sdo) else $error("ro bit");
	chk_echo_pad: assert property (@(posedge sclk) disable iff (!rstn)
		cnt_q[5:3] == 3'h3 |-> !sdo) else $error("pad bit");

	// main scenarios reached
	cover property (@(posedge sclk) cnt_q == 6'h1f);
	cover property (@(posedge sclk) cnt_q == 6'h10 && cmd_q[15:8] == {ADDR_CMD_ECHO, 1'b1});
	cover property (@(posedge clk) $changed(prevCommand));
endmodule

bind alc_regs alc_regs_assertions u_chk (.*);

// ### testbench/alc_host_model.sv
`timescale 1ns/1ps
// host side; sclk rests low between frames
module alc_host_model
(
	// serial port
	output logic		sclk = 1'b0,
	output logic		csN = 1'b1,
	output logic		sdi = 1'b0,
	input wire logic	sdo
);
	// frame of n clocks, word msb first; read byte taken at rising edges 17..24
	task automatic frame(input logic [15:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		csN = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			sdi = i < 16 ? w[15 - i] : ~sdi; // spent line keeps toggling
			#7.5;
			if (i > 15 && i < 24)
				rd = {rd[6:0], sdo};
			sclk = 1'b1;
			#7.5;
			sclk = 1'b0;
		end
		#7.5;
		csN = 1'b1;
		// select stays high for a full period so the async frame clear really fires
		#15;
	endtask
endmodule

// ### testbench/test_alc_regs.sv
`timescale 1ns/1ps
// register traffic through the host model, echo tracked alongside
module test_alc_regs
	import alc_pkg::*;
;
	logic			clk;
	logic			rstn;
	logic [NUM_CH-1:0][7:0]	lowAlarmMsb;
	alc_thr_t [NUM_CH-1:0]	lowAlarmThreshold;
	logic [7:0]		prevCommand;
	logic			sclk;
	logic			csN;
	logic			sdi;
	logic			sdo;
	logic [7:0]		echo;
	logic [7:0]		rd;
	logic [6:0]		a;
	int			failures;
	int			total_checks;

	alc_regs DUT (.*);
	alc_host_model host (.*);

	// system clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one frame; reads stop after 24 clocks, writes run 32 to expose the pad
	task automatic xfer(input logic [6:0] ad, input logic wr, input logic [7:0] d, exp);
		host.frame({ad, wr, d}, wr ? 32 : 24, rd);
		if (!wr)
			check({8'h00, rd}, {8'h00, exp});
		if (!wr || ad != ADDR_CMD_ECHO)
			echo = {ad, wr};
	endtask

	task automatic final_report;
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// main sequence
	initial
	begin
		rstn = 1'b0;
		lowAlarmMsb = '0;
		failures = 0;
		total_checks = 0;
		echo = ECHO_RESET;
		fork
			host.frame(16'h0000, 8, rd); // link side needs clocks to see reset
		join_none
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		lowAlarmMsb <= 64'hf7e6d5c4b3a29180;
		host.frame(16'h0000, 8, rd);
		xfer(ADDR_CMD_ECHO, 1'b0, 8'h00, echo);
		for (int i = 0; i < 16; i++)
		begin
			a = ADDR_LT_LSB_CH0 + ADDR_CH_STRIDE * 7'(i % 8);
			xfer(a, 1'b0, 8'h00, i < 8 ? 8'h00 : {4'(i - 8), 4'h0});
			xfer(a, 1'b1, {4'(i), 4'hf}, 8'h00);
			xfer(a, 1'b0, 8'h00, {4'(i), 4'h0});
			check(lowAlarmThreshold[i % 8], {lowAlarmMsb[i % 8], 4'(i), 4'h0});
		end
		xfer(ADDR_CMD_ECHO, 1'b0, 8'h00, echo);
		xfer(ADDR_CMD_ECHO, 1'b1, 8'h55, 8'h00);
		xfer(ADDR_CMD_ECHO, 1'b0, 8'h00, echo);
		xfer(7'h10, 1'b0, 8'h00, 8'h00);
		xfer(ADDR_CMD_ECHO, 1'b0, 8'h00, echo);
		// long idle so the echo-hold check sees a quiet select
		repeat (8) @(posedge clk);
		check({8'h00, prevCommand}, {8'h00, echo});
		host.frame({ADDR_LT_LSB_CH0, 1'b1, 8'h30}, 12, rd);
		xfer(ADDR_LT_LSB_CH0, 1'b0, 8'h00, 8'h80);
		@(posedge clk);
		lowAlarmMsb[0] <= 8'h3c;
		repeat (2) @(posedge clk);
		check(lowAlarmThreshold[0], 16'h3c80);
		final_report;
	end
endmodule
